//--- include/tbpw_regs.vh
`ifndef TBPW_REGS_VH
`define TBPW_REGS_VH
// ------------------------------------------------------------
// Register offsets (channel A at 0..2, channel B at 4..6)
// ------------------------------------------------------------
`define TBPW_ADDR_W 4
`define TBPW_OFF_CTRL 4'h0
`define TBPW_OFF_DCH 4'h1
`define TBPW_OFF_DCL 4'h2
`define TBPW_CH_STRIDE 4'h4
// ------------------------------------------------------------
// Control and duty-low field positions
// ------------------------------------------------------------
`define TBPW_CTRL_EN 7
`define TBPW_CTRL_OUT 5
`define TBPW_CTRL_POL 4
`define TBPW_DCL_LSB_HI 7
`define TBPW_DCL_LSB_LO 6
// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define TBPW_RST_CTRL 8'h00
`define TBPW_RST_DUTY 10'h000
`define TBPW_RST_COUNT 2'h0
`endif

//--- rtl/tbpw_duty_store.v
`timescale 1ns/100ps
`default_nettype none
`include "tbpw_regs.vh"
// Buffered duty words for both channels; read data from a register
module tbpw_duty_store
(
    input wire clk_sys,
    input wire reset,
    input wire wrEn,
    input wire wrIdx,
    input wire wrHigh,
    input wire [7:0] wrData,
    input wire rdIdx,
    input wire rdHigh,
    output reg [7:0] rdData,
    output wire [19:0] dutyFlat
);
    reg [9:0] duty_r [0:1];
    genvar g;

    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            duty_r[0] <= `TBPW_RST_DUTY;
            duty_r[1] <= `TBPW_RST_DUTY;
            rdData <= 8'h00;
        end
        else
        begin
            if (wrEn && wrHigh)
                duty_r[wrIdx] <= {wrData, duty_r[wrIdx][1:0]};
            else if (wrEn)
                duty_r[wrIdx] <= {duty_r[wrIdx][9:2],
                    wrData[`TBPW_DCL_LSB_HI:`TBPW_DCL_LSB_LO]};
            if (rdHigh)
                rdData <= duty_r[rdIdx][9:2];
            else
                rdData <= {duty_r[rdIdx][1:0], 6'h00};
        end
    end

    generate
        for (g = 0; g < 2; g = g + 1)
        begin : gOut
            assign dutyFlat[g*10 +: 10] = duty_r[g];
        end
    endgenerate
endmodule // tbpw_duty_store
`default_nettype wire

//--- rtl/tbpw_pwm.v
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "tbpw_regs.vh"
// Summary of operation
// [R1] Two identical channels, each with own control, duty registers, output.
// [R2] Idle output level is 0 with polarity clear, 1 with polarity set.
// [R3] Enable clear holds output at the idle level.
// [R4] Each channel picks one of three 8-bit timers via external select.
// [R5] Software clocks the chosen timer from the system clock over four.
// [R6] Period is (period value + 1) times 4 clocks times prescale.
// [R7] After count equals period, timer clears and a new period begins.
// [R8] New period drives output active unless latched duty is zero.
// [R9] Duty is double-buffered; copied to compare latch only at period match.
// [R10] Duty is left-justified: high register bits 9..2, low register bits 7..6.
// [R11] Time base is 10 bits: timer count plus clock or prescaler bits.
// [R12] Pulse width equals duty times one clock times prescale.
// [R13] Duty above period leaves output active all period.
// [R14] Resolution is log2 of 4 times (period + 1); ten bits at 255.
// [R15] Sleep freezes time base, state and output level.
// [R16] Output frequency scales with the system clock.
// [R17] Any reset restores register defaults; pins revert to input.
// [R18] Software clears the direction bit before the pin shows the output.
// [R19] Software follows the setup order for a complete first cycle.
// [R20] A read-only control bit returns the current output level.
// [R21] Polarity set means active-low, clear means active-high.
// [R22] Output goes inactive when the 10-bit time base reaches the duty.
module tbpw_pwm
(
    input wire clk_sys,
    input wire reset,
    input wire [3:0] regAddr,
    input wire [7:0] regWrData,
    input wire regWrite,
    input wire regRead,
    output reg [7:0] regRdData,
    input wire [23:0] timerCount,
    input wire [2:0] timerMatch,
    input wire [5:0] prescaleBits,
    input wire [2:0] prescaleOne,
    input wire [3:0] timerSelect,
    input wire sleepMode,
    input wire [1:0] portDirection,
    output wire [1:0] pwmOut,
    output wire [1:0] pwmPinOut,
    output wire [1:0] pwmPinOe
);
    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    // Returned at the full address width so it meets the offset macros bit for bit
    function [3:0] decodeReg;
        input [3:0] a;
        begin
            decodeReg = {2'h0, a[1:0]};
        end
    endfunction

    localparam [7:0] RST_CTRL = `TBPW_RST_CTRL;

    wire hitCh = regAddr[2];
    wire mapped = (regAddr[3] == 1'b0) && (decodeReg(regAddr) != 4'h3);
    wire wrCtrl = regWrite && mapped && (decodeReg(regAddr) == `TBPW_OFF_CTRL);
    wire wrDuty = regWrite && mapped && (decodeReg(regAddr) != `TBPW_OFF_CTRL);
    wire [7:0] dutyRd;
    wire [19:0] dutyFlat;
    reg rdCtrl_r;
    reg rdMapped_r;
    reg rdCh_r;

    // Writes land at once, so a read right after a write sees new data
    tbpw_duty_store uStore
    (
        .clk_sys(clk_sys),
        .reset(reset),
        .wrEn(wrDuty && !sleepMode),
        .wrIdx(hitCh),
        .wrHigh(decodeReg(regAddr) == `TBPW_OFF_DCH),
        .wrData(regWrData),
        .rdIdx(hitCh),
        .rdHigh(decodeReg(regAddr) == `TBPW_OFF_DCH),
        .rdData(dutyRd),
        .dutyFlat(dutyFlat)
    ); // R9 R10

    // ------------------------------------------------------------
    // Per-channel modulator
    // ------------------------------------------------------------
    reg [1:0] enable_r;
    reg [1:0] polarity_r;
    reg [1:0] active_r;
    reg [1:0] phase_r;
    wire [7:0] ctrlView [0:1];
    genvar g;

    generate
        for (g = 0; g < 2; g = g + 1) // R1
        begin : gCh
            localparam [0:0] CH_IDX = g;
            reg [9:0] dutyLatch_r;
            wire [1:0] sel = timerSelect[g*2 +: 2];
            wire selOk = (sel != 2'h3);
            // Timer count, match and prescaler of the chosen timer
            wire [7:0] cnt = selOk ? timerCount[sel*8 +: 8] : 8'h00; // R4
            wire match = selOk ? timerMatch[sel] : 1'b0;
            wire [1:0] psc = selOk ? prescaleBits[sel*2 +: 2] : 2'h0;
            wire oneToOne = selOk ? prescaleOne[sel] : 1'b1;
            // Low bits follow the system clock phase at 1:1, else prescaler
            wire [1:0] low = oneToOne ? phase_r : psc; // R11
            wire [9:0] base = {cnt, low}; // R11 R14
            wire [9:0] dutyBuf = dutyFlat[g*10 +: 10];
            wire reached = (base == dutyLatch_r); // R22

            always @(posedge clk_sys)
            begin
                if (reset)
                begin
                    enable_r[g] <= RST_CTRL[`TBPW_CTRL_EN]; // R17
                    polarity_r[g] <= RST_CTRL[`TBPW_CTRL_POL];
                    active_r[g] <= 1'b0;
                    dutyLatch_r <= `TBPW_RST_DUTY;
                end
                else if (!sleepMode) // R15
                begin
                    if (wrCtrl && hitCh == CH_IDX)
                    begin
                        enable_r[g] <= regWrData[`TBPW_CTRL_EN];
                        polarity_r[g] <= regWrData[`TBPW_CTRL_POL]; // R21
                    end
                    // Period match is the only point the duty latch updates
                    if (match && phase_r == 2'h3)
                    begin
                        dutyLatch_r <= dutyBuf; // R9
                        active_r[g] <= (dutyBuf != 10'h000); // R7 R8
                    end
                    else if (reached) // R22 R12 R13
                        active_r[g] <= 1'b0;
                end
            end

            // Disabled output rests at the idle level set by polarity
            // Mask the cycle in which the base meets the duty, else the pulse runs one clock long
            wire level = active_r[g] && !reached; // R12 R22
            assign pwmOut[g] = enable_r[g] ? (level ^ polarity_r[g])
                                           : polarity_r[g]; // R2 R3 R21
            assign pwmPinOut[g] = pwmOut[g];
            assign pwmPinOe[g] = !portDirection[g] && !reset; // R17 R18
            assign ctrlView[g] = {enable_r[g], 1'b0, pwmOut[g], polarity_r[g], 4'h0}; // R20
        end
    endgenerate

    // ------------------------------------------------------------
    // Clock phase: four system clocks per timer increment
    // ------------------------------------------------------------
    always @(posedge clk_sys)
    begin
        if (reset)
            phase_r <= `TBPW_RST_COUNT;
        else if (!sleepMode) // R15 R16
            phase_r <= phase_r + 2'h1; // R6
    end

    // ------------------------------------------------------------
    // Read path: data one cycle after the strobe
    // ------------------------------------------------------------
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            rdCtrl_r <= 1'b0;
            rdMapped_r <= 1'b0;
            rdCh_r <= 1'b0;
        end
        else
        begin
            rdCtrl_r <= regRead && (decodeReg(regAddr) == `TBPW_OFF_CTRL);
            rdMapped_r <= regRead && mapped;
            rdCh_r <= hitCh;
        end
    end

    always @*
    begin
        if (!rdMapped_r)
            regRdData = 8'h00;
        else if (rdCtrl_r)
            regRdData = ctrlView[rdCh_r]; // R20
        else
            regRdData = dutyRd;
    end
endmodule // tbpw_pwm
`default_nettype wire

//--- dv/tbpw_pwm_properties.sv
`timescale 1ns/100ps
`default_nettype none
module tbpw_pwm_properties
(
    input wire clk_sys,
    input wire reset,
    input wire [3:0] regAddr,
    input wire [7:0] regWrData,
    input wire regWrite,
    input wire regRead,
    input wire [7:0] regRdData,
    input wire [23:0] timerCount,
    input wire [2:0] timerMatch,
    input wire [5:0] prescaleBits,
    input wire [2:0] prescaleOne,
    input wire [3:0] timerSelect,
    input wire sleepMode,
    input wire [1:0] portDirection,
    input wire [1:0] pwmOut,
    input wire [1:0] pwmPinOut,
    input wire [1:0] pwmPinOe
);
    // Shadow of both control registers; writes in sleep are dropped
    reg [7:0] ctl_r [0:1];
    always @(posedge clk_sys)
        if (reset)
        begin
            ctl_r[0] <= 8'h00;
            ctl_r[1] <= 8'h00;
        end
        else if (regWrite && regAddr[1:0] == 2'h0 && !regAddr[3] && !sleepMode)
            ctl_r[regAddr[2]] <= regWrData;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    sequence s_rd_ctl;
        regRead && regAddr == 4'h0;
    endsequence
    a_oe_dir: assert property (pwmPinOe == (~portDirection & {2{!reset}}))
        else $error("pin enable");
    a_pin_same: assert property (pwmPinOut == pwmOut) else $error("pin level");
    a_idle_a: assert property (!ctl_r[0][7] |-> pwmOut[0] == ctl_r[0][4]) else $error("idle a");
    a_idle_b: assert property (!ctl_r[1][7] |-> pwmOut[1] == ctl_r[1][4]) else $error("idle b");
    a_sleep_hold: assert property (sleepMode |=> $stable(pwmOut)) else $error("sleep");
    a_start_act: assert property ($rose(pwmOut[0]) && ctl_r[0][7] && $past(ctl_r[0][7])
        && !ctl_r[0][4] && !$past(ctl_r[0][4]) |-> $past(timerMatch[timerSelect[1:0]]))
        else $error("start");
    a_rd_ctrl: assert property (s_rd_ctl |=> regRdData == {$past(ctl_r[0][7]), 1'b0,
        pwmOut[0], $past(ctl_r[0][4]), 4'h0}) else $error("ctrl read");
    a_rd_dcl: assert property (regRead && regAddr == 4'h6 |=> regRdData[5:0] == 6'h00)
        else $error("low duty read");
endmodule // tbpw_pwm_properties
`default_nettype wire

//--- dv/tbpw_timer_model.sv
`timescale 1ns/100ps
`default_nettype none
// Three auto-reload timers, each stepping once per four system clocks
module tbpw_timer_model
#(
    parameter logic [23:0] PERIODS = 24'h030507
)
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic sleepMode,
    output logic [23:0] timerCount,
    output logic [2:0] timerMatch
);
    logic [1:0] phase_r;
    always_ff @(posedge clk_sys)
        if (reset)
        begin
            phase_r <= 2'h0;
            timerCount <= 24'h0;
        end
        else if (!sleepMode)
        begin
            phase_r <= phase_r + 2'h1;
            for (int i = 0; i < 3; i++)
                if (phase_r == 2'h3)
                    timerCount[8*i +: 8] <= timerMatch[i] ? 8'h00 : timerCount[8*i +: 8] + 8'h01;
        end
    always_comb
        for (int j = 0; j < 3; j++)
            timerMatch[j] = timerCount[8*j +: 8] == PERIODS[8*j +: 8];
endmodule // tbpw_timer_model
`default_nettype wire

//--- dv/tbpw_pwm_tb.sv
`timescale 1ns/100ps
`default_nettype none
module tbpw_pwm_tb;
    logic clk_sys, reset, regWrite, regRead, sleepMode;
    logic [3:0] regAddr, timerSelect;
    logic [7:0] regWrData, regRdData, ctl[2], dch[2], dcl[2];
    logic [23:0] timerCount;
    logic [2:0] timerMatch;
    logic [1:0] portDirection, pwmOut, pwmPinOut, pwmPinOe;
    logic [31:0] seed = 32'hd501b730;
    logic [31:0] r;
    int ph, dl[2], err_count, n_compared;
    tbpw_pwm u_tbpw_pwm (.clk_sys, .reset, .regAddr, .regWrData, .regWrite, .regRead, .regRdData,
        .timerCount, .timerMatch, .prescaleBits(6'h00), .prescaleOne(3'h7), .timerSelect,
        .sleepMode, .portDirection, .pwmOut, .pwmPinOut, .pwmPinOe);
    tbpw_timer_model u_tbpw_timer_model (.clk_sys, .reset, .sleepMode, .timerCount, .timerMatch);
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Active while the 10-bit time base is below the latched duty
    function automatic logic expOut(int c);
        int tb = timerCount[8*timerSelect[2*c +: 2] +: 8] * 4 + ph;
        return ctl[c][7] ? ctl[c][4] ^ (tb < dl[c]) : ctl[c][4];
    endfunction
    task automatic check(logic [7:0] seen, logic [7:0] want);
        n_compared++;
        if (seen !== want)
        begin
            err_count++;
            $display("[FAIL] %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic wr(logic [3:0] a, logic [7:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge clk_sys);
        regWrite <= 1'b0;
    endtask
    task automatic rd(logic [3:0] a);
        logic [7:0] want;
        @(posedge clk_sys);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk_sys);
        regRead <= 1'b0;
        @(negedge clk_sys);
        want = a[1:0] == 2'h0 ? ctl[a[2]] : a[1:0] == 2'h1 ? dch[a[2]] : dcl[a[2]];
        check(regRdData & 8'hdf, (a[3] || a[1:0] == 2'h3) ? 8'h00 : want & 8'hdf);
    endtask
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge clk_sys)
        if (reset)
        begin
            ph <= 0;
            dl <= '{0, 0};
            ctl <= '{8'h00, 8'h00};
            dch <= '{8'h00, 8'h00};
            dcl <= '{8'h00, 8'h00};
        end
        else if (!sleepMode)
        begin
            ph <= (ph + 1) % 4;
            for (int c = 0; c < 2; c++)
                if (ph == 3 && timerMatch[timerSelect[2*c +: 2]])
                    dl[c] <= {dch[c], dcl[c][7:6]};
            if (regWrite && !regAddr[3])
                case (regAddr[1:0])
                    2'h0: ctl[regAddr[2]] <= regWrData & 8'h90;
                    2'h1: dch[regAddr[2]] <= regWrData;
                    2'h2: dcl[regAddr[2]] <= regWrData & 8'hc0;
                    default: ;
                endcase
        end
    always @(negedge clk_sys)
        if (!reset)
            for (int c = 0; c < 2; c++)
                check(8'(pwmOut[c]), 8'(expOut(c)));
    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    initial
    begin
        repeat (5000) @(posedge clk_sys);
        err_count++;
        report_and_stop;
    end
    initial
    begin
        {regAddr, regWrData, regWrite, regRead, sleepMode} = '0;
        timerSelect = 4'h8;
        portDirection = 2'h3;
        reset = 1'b1;
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        for (int a = 0; a < 10; a++)
            rd(a[3:0]);
        @(posedge clk_sys);
        portDirection <= 2'h0;
        for (int i = 0; i < 10; i++)
        begin
            r = xs();
            wr({1'b0, i[0], 2'h1}, {3'h0, r[12:8] & {5{i != 3}}});
            wr({1'b0, i[0], 2'h2}, r[7:0] & {8{i != 3}});
            wr({1'b0, i[0], 2'h0}, {i > 1, 2'h0, r[16], 4'h0});
            rd({1'b0, i[0], 2'h2});
            rd({1'b0, i[0], 2'h0});
            @(posedge clk_sys);
            sleepMode <= r[18];
            if (r[18])
                wr({1'b0, i[0], 2'h0}, 8'h10);
            repeat (40) @(posedge clk_sys);
            sleepMode <= 1'b0;
            repeat (150) @(posedge clk_sys);
        end
        reset <= 1'b1;
        @(posedge clk_sys);
        reset <= 1'b0;
        rd(4'h0);
        rd(4'h5);
        report_and_stop;
    end
endmodule // tbpw_pwm_tb
bind tbpw_pwm tbpw_pwm_properties u_tbpw_pwm_properties (.clk_sys, .reset, .regAddr, .regWrData,
    .regWrite, .regRead, .regRdData, .timerCount, .timerMatch, .prescaleBits, .prescaleOne,
    .timerSelect, .sleepMode, .portDirection, .pwmOut, .pwmPinOut, .pwmPinOe);
`default_nettype wire
